// [src/tbid_decoder.sv]
// instruction decoder with four-phase cycle timing and id store access
// What this block does
// RQ1: takes one 12-bit word, splits opcode from operand fields
// RQ2: byte ops select one of 32 file registers by file_select
// RQ3: byte ops write working_register when dest_select is 0, file when 1
// RQ4: bit ops pick bit of an 8-bit file register via bit_select
// RQ5: literal ops yield an 8-bit or 9-bit immediate constant
// RQ6: one instruction cycle, two when a skip is taken or pc changes
// RQ7: each instruction cycle is exactly four oscillator periods
// RQ8: four id words, reachable only in program/verify mode
// RQ9: programmer should store data in low 4 bits, upper 8 all ones
// RQ10: don't-care encoding bits never change the decoded behaviour
// RQ11: byte ops: bit 5 dest_select, bits 4..0 file_select, top six opcode
// RQ12: every pc write except the unconditional branch clears pc bit 8
// RQ13: after a taken skip or pc change the prefetched word becomes a no-op
// RQ14: no register write occurs in a discarded cycle
`timescale 1ns/1ps
`default_nettype none
module tbid_decoder
	import tbid_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// instruction fetch
	input  wire logic [INSTR_W-1:0]   instr_in,
	output logic                      fetch_strobe,
	// execution feedback
	input  wire logic                 skip_true,
	// decoded fields
	output var  logic [5:0]           opcode_r,
	output var  tbid_class_t          class_r,
	output var  logic [FSEL_W-1:0]    file_select_r,
	output var  logic                 dest_select_r,
	output var  logic [2:0]           bit_select_r,
	output var  logic [LIT_W-1:0]     literal_r,
	output var  logic                 literal_wide_r,
	output var  tbid_ctl_t            ctl_op_r,
	output var  logic                 is_skip_r,
	output var  logic                 discard_r,
	output var  tbid_phase_t          phase_r,
	// result routing strobes, at the last phase
	output logic                      w_write,
	output logic                      f_write,
	output logic                      pc_write,
	output logic                      pc_bit8_clear,
	// identification store (programming pins)
	input  wire logic                 prog_mode_pin,
	input  wire logic                 id_we,
	input  wire logic                 id_re,
	input  wire logic [ID_ADDR_W-1:0] id_addr,
	input  wire logic [INSTR_W-1:0]   id_wdata,
	output var  logic [INSTR_W-1:0]   id_rdata_r,
	output var  logic                 id_rvalid_r
);
	// phase sequencer
	tbid_phase_t phase_nxt;
	logic        last_phase;

	always_comb begin
		unique case (phase_r)
			TBID_Q1: phase_nxt = TBID_Q2;
			TBID_Q2: phase_nxt = TBID_Q3;
			TBID_Q3: phase_nxt = TBID_Q4;
			TBID_Q4: phase_nxt = TBID_Q1; // [RQ7]
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			phase_r <= TBID_Q1;
		else
			phase_r <= phase_nxt;
	end

	assign last_phase   = (phase_r == TBID_Q4);
	assign fetch_strobe = last_phase;

	// combinational decode of the fetched word
	logic [5:0]        dec_opc;
	tbid_class_t       dec_cls;
	logic [FSEL_W-1:0] dec_fsel;
	logic              dec_dest;
	logic [2:0]        dec_bsel;
	logic [LIT_W-1:0]  dec_lit;
	logic              dec_wide;
	tbid_ctl_t         dec_ctl;
	logic              dec_skip;
	logic              dec_wr_w;
	logic              dec_wr_f;
	logic              dec_pc;

	always_comb begin
		dec_opc  = instr_in[INSTR_W-1:OPC_LSB]; // [RQ1] [RQ11]
		dec_cls  = TBID_CLS_CTRL;
		dec_fsel = '0;
		dec_dest = 1'b0;
		dec_bsel = '0;
		dec_lit  = '0;
		dec_wide = 1'b0;
		dec_ctl  = TBID_CTL_NONE;
		dec_skip = 1'b0;
		dec_wr_w = 1'b0;
		dec_wr_f = 1'b0;
		dec_pc   = 1'b0;
		unique case (instr_in[11:10])
			2'b00: begin
				if (instr_in[11:5] == 7'h00) begin
					// control word; unlisted codes behave as a no-op
					if (instr_in[4:0] == CTL_OPTION)
						dec_ctl = TBID_CTL_OPTION;
					else if (instr_in[4:0] == CTL_SLEEP)
						dec_ctl = TBID_CTL_SLEEP;
					else if (instr_in[4:0] == CTL_CLRWDT)
						dec_ctl = TBID_CTL_CLRWDT;
					else if (instr_in[4:3] == 2'b00 && instr_in[2:0] >= CTL_TRIS_MIN) begin
						dec_ctl  = TBID_CTL_TRIS;
						dec_fsel = {2'b00, instr_in[2:0]};
					end
				end else begin
					dec_cls  = TBID_CLS_BYTE;
					dec_fsel = instr_in[FSEL_W-1:0]; // [RQ2] [RQ11]
					dec_dest = instr_in[DEST_BIT];   // [RQ11]
					if (dec_opc == OPC_CLR && !instr_in[DEST_BIT])
						dec_fsel = '0; // clear-w ignores its file bits [RQ10]
					dec_wr_w = !dec_dest; // [RQ3]
					dec_wr_f = dec_dest;  // [RQ3]
					dec_skip = (dec_opc == OPC_DECFSZ) || (dec_opc == OPC_INCFSZ);
				end
			end
			2'b01: begin
				dec_cls  = TBID_CLS_BIT;
				dec_fsel = instr_in[FSEL_W-1:0];
				dec_bsel = instr_in[BSEL_LSB+2:BSEL_LSB]; // [RQ4]
				dec_skip = instr_in[9:8] >= BIT_TEST_SC;
				dec_wr_f = !dec_skip; // set/clear write the file back [RQ4]
			end
			2'b10: begin
				dec_cls = TBID_CLS_LIT;
				dec_pc  = 1'b1;
				if (instr_in[11:9] == TOP_GOTO) begin
					dec_lit  = instr_in[8:0]; // [RQ5]
					dec_wide = 1'b1;
				end else begin
					dec_lit = {1'b0, instr_in[7:0]}; // [RQ5]
					if (instr_in[11:8] == TOP_CALL)
						dec_ctl = TBID_CTL_CALL;
					else begin
						dec_ctl  = TBID_CTL_RETURN;
						dec_wr_w = (instr_in[11:8] == TOP_RETLW);
					end
				end
			end
			2'b11: begin
				dec_cls  = TBID_CLS_LIT;
				dec_lit  = {1'b0, instr_in[7:0]}; // [RQ5]
				dec_wr_w = 1'b1;
			end
		endcase
		// a file write to the low pc byte is a program-counter change
		if (dec_wr_f && dec_fsel == PC_LOW_ADDR)
			dec_pc = 1'b1;
	end

	// registered decode; a discarded word loads as a no-op
	logic [5:0]        opcode_nxt;
	tbid_class_t       class_nxt;
	logic [FSEL_W-1:0] fsel_nxt;
	logic              dest_nxt;
	logic [2:0]        bsel_nxt;
	logic [LIT_W-1:0]  lit_nxt;
	logic              wide_nxt;
	tbid_ctl_t         ctl_nxt;
	logic              skip_nxt;
	logic              discard_nxt;
	logic              wr_w_r, wr_w_nxt;
	logic              wr_f_r, wr_f_nxt;
	logic              pc_r, pc_nxt;
	logic              taken;

	assign taken = (is_skip_r && skip_true) || pc_r; // [RQ6]

	always_comb begin
		opcode_nxt  = opcode_r;
		class_nxt   = class_r;
		fsel_nxt    = file_select_r;
		dest_nxt    = dest_select_r;
		bsel_nxt    = bit_select_r;
		lit_nxt     = literal_r;
		wide_nxt    = literal_wide_r;
		ctl_nxt     = ctl_op_r;
		skip_nxt    = is_skip_r;
		discard_nxt = discard_r;
		wr_w_nxt    = wr_w_r;
		wr_f_nxt    = wr_f_r;
		pc_nxt      = pc_r;
		if (last_phase) begin
			discard_nxt = taken; // [RQ6] [RQ13]
			opcode_nxt  = taken ? '0 : dec_opc;
			class_nxt   = taken ? TBID_CLS_CTRL : dec_cls;
			fsel_nxt    = taken ? '0 : dec_fsel;
			dest_nxt    = taken ? 1'b0 : dec_dest;
			bsel_nxt    = taken ? '0 : dec_bsel;
			lit_nxt     = taken ? '0 : dec_lit;
			wide_nxt    = taken ? 1'b0 : dec_wide;
			ctl_nxt     = taken ? TBID_CTL_NONE : dec_ctl;
			skip_nxt    = taken ? 1'b0 : dec_skip;
			wr_w_nxt    = taken ? 1'b0 : dec_wr_w; // [RQ13]
			wr_f_nxt    = taken ? 1'b0 : dec_wr_f; // [RQ13]
			pc_nxt      = taken ? 1'b0 : dec_pc;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			opcode_r       <= '0;
			class_r        <= TBID_CLS_CTRL;
			file_select_r  <= '0;
			dest_select_r  <= 1'b0;
			bit_select_r   <= '0;
			literal_r      <= '0;
			literal_wide_r <= 1'b0;
			ctl_op_r       <= TBID_CTL_NONE;
			is_skip_r      <= 1'b0;
			discard_r      <= 1'b0;
			wr_w_r         <= 1'b0;
			wr_f_r         <= 1'b0;
			pc_r           <= 1'b0;
		end else begin
			opcode_r       <= opcode_nxt;
			class_r        <= class_nxt;
			file_select_r  <= fsel_nxt;
			dest_select_r  <= dest_nxt;
			bit_select_r   <= bsel_nxt;
			literal_r      <= lit_nxt;
			literal_wide_r <= wide_nxt;
			ctl_op_r       <= ctl_nxt;
			is_skip_r      <= skip_nxt;
			discard_r      <= discard_nxt;
			wr_w_r         <= wr_w_nxt;
			wr_f_r         <= wr_f_nxt;
			pc_r           <= pc_nxt;
		end
	end

	// strobes fire only at the last phase, after a full decode
	assign w_write       = last_phase && wr_w_r && !discard_r; // [RQ3] [RQ14]
	assign f_write       = last_phase && wr_f_r && !discard_r; // [RQ3] [RQ14]
	assign pc_write      = last_phase && pc_r;
	assign pc_bit8_clear = pc_write && !literal_wide_r; // [RQ12]

	// program/verify mode comes from a pin; id strobes are honoured only there
	logic prog_meta_r, prog_sync_r;
	logic id_acc_we, id_acc_re;

	always_ff @(posedge clock) begin
		if (rst) begin
			prog_meta_r <= 1'b0;
			prog_sync_r <= 1'b0;
			id_rvalid_r <= 1'b0;
		end else begin
			prog_meta_r <= prog_mode_pin;
			prog_sync_r <= prog_meta_r;
			id_rvalid_r <= id_acc_re;
		end
	end

	assign id_acc_we = prog_sync_r && id_we; // [RQ8]
	assign id_acc_re = prog_sync_r && id_re; // [RQ8]

	tbid_id_mem u_id_mem (
		.clock   (clock),
		.rst     (rst),
		.we      (id_acc_we),
		.re      (id_acc_re),
		.addr    (id_addr),
		.wdata   (id_wdata),
		.rdata_r (id_rdata_r)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_full_cycle;
		phase_r == TBID_Q2 ##1 phase_r == TBID_Q3 ##1 phase_r == TBID_Q4;
	endsequence

	a_phase_four_periods: assert property (phase_r == TBID_Q1 |=> s_full_cycle ##1 phase_r == TBID_Q1) // [RQ7]
		else $error("instruction cycle is not four clocks");
	a_write_after_decode: assert property ((w_write || f_write) |-> last_phase && !discard_r) // [RQ14]
		else $error("register write outside the last phase");
	a_discard_no_effect: assert property (discard_r |-> !w_write && !f_write && !pc_write) // [RQ13]
		else $error("discarded cycle produced an effect");
	a_skip_two_cycles: assert property (last_phase && is_skip_r && skip_true |=> discard_r [*4] ##1 !discard_r) // [RQ6]
		else $error("taken skip did not cost exactly one extra cycle");
	a_pc_two_cycles: assert property (pc_write |=> discard_r [*4]) // [RQ6]
		else $error("pc change did not discard the prefetch");
	a_single_cycle: assert property (last_phase && !pc_r && !(is_skip_r && skip_true) |=> !discard_r) // [RQ6]
		else $error("plain instruction took two cycles");
	a_byte_route: assert property (last_phase && class_r == TBID_CLS_BYTE |-> w_write == !dest_select_r && f_write == dest_select_r) // [RQ3]
		else $error("byte result routed to the wrong place");
	a_pc8_goto_kept: assert property (pc_write && opcode_r[5:3] == TOP_GOTO |-> !pc_bit8_clear) // [RQ12]
		else $error("unconditional branch cleared pc bit 8");
	a_pc8_others_clear: assert property (pc_write && opcode_r[5:3] != TOP_GOTO |-> pc_bit8_clear) // [RQ12]
		else $error("pc write kept pc bit 8");
	a_id_only_prog: assert property (id_rvalid_r |-> $past(prog_sync_r)) // [RQ8]
		else $error("id read outside program/verify mode");
endmodule // tbid_decoder
`default_nettype wire

// [src/tbid_id_mem.sv]
// four-word identification store with registered read data
`timescale 1ns/1ps
`default_nettype none
module tbid_id_mem
	import tbid_pkg::*;
(
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// access port
	input  wire logic                 we,
	input  wire logic                 re,
	input  wire logic [ID_ADDR_W-1:0] addr,
	input  wire logic [INSTR_W-1:0]   wdata,
	output var  logic [INSTR_W-1:0]   rdata_r
);
	logic [INSTR_W-1:0] mem_r [ID_WORDS];
	logic [INSTR_W-1:0] rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (re)
			rdata_nxt = mem_r[addr];
	end

	// contents are not reset: the store models nonvolatile words
	always_ff @(posedge clock) begin
		if (we)
			mem_r[addr] <= wdata;
	end

	always_ff @(posedge clock) begin
		if (rst)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end
endmodule // tbid_id_mem
`default_nettype wire

// [src/tbid_pkg.sv]
// shared constants and types for the twelve-bit instruction decoder
package tbid_pkg;
	localparam int          INSTR_W      = 12;
	localparam int          FSEL_W       = 5;
	localparam int          LIT_W        = 9;
	localparam int          ID_WORDS     = 4;
	localparam int          ID_ADDR_W    = 2;
	localparam int          PHASES       = 4;
	// file register holding the low program-counter byte
	localparam logic [4:0]  PC_LOW_ADDR  = 5'h02;
	// field positions inside the instruction word
	localparam int          DEST_BIT     = 5;
	localparam int          BSEL_LSB     = 5;
	localparam int          OPC_LSB      = 6;
	// opcode patterns (upper six bits unless noted)
	localparam logic [5:0]  OPC_DECFSZ   = 6'h0b;
	localparam logic [5:0]  OPC_INCFSZ   = 6'h0f;
	localparam logic [5:0]  OPC_MOVWF_HI = 6'h00;
	localparam logic [5:0]  OPC_CLR      = 6'h01;
	localparam logic [3:0]  TOP_RETLW    = 4'h8;
	localparam logic [3:0]  TOP_CALL     = 4'h9;
	localparam logic [2:0]  TOP_GOTO     = 3'h5;
	localparam logic [1:0]  BIT_TEST_SC  = 2'h2;
	// control word low bits
	localparam logic [4:0]  CTL_OPTION   = 5'h02;
	localparam logic [4:0]  CTL_SLEEP    = 5'h03;
	localparam logic [4:0]  CTL_CLRWDT   = 5'h04;
	localparam logic [2:0]  CTL_TRIS_MIN = 3'h5;

	typedef enum logic [1:0] {
		TBID_Q1 = 2'b00,
		TBID_Q2 = 2'b01,
		TBID_Q3 = 2'b11,
		TBID_Q4 = 2'b10
	} tbid_phase_t;

	typedef enum logic [1:0] {
		TBID_CLS_CTRL = 2'h0,
		TBID_CLS_BYTE = 2'h1,
		TBID_CLS_BIT  = 2'h2,
		TBID_CLS_LIT  = 2'h3
	} tbid_class_t;

	typedef enum logic [2:0] {
		TBID_CTL_NONE   = 3'h0,
		TBID_CTL_OPTION = 3'h1,
		TBID_CTL_SLEEP  = 3'h2,
		TBID_CTL_CLRWDT = 3'h3,
		TBID_CTL_TRIS   = 3'h4,
		TBID_CTL_CALL   = 3'h5,
		TBID_CTL_RETURN = 3'h6
	} tbid_ctl_t;
endpackage

// [test/tbid_prog_mem.sv]
// program memory model supplying twelve-bit words to the decoder
`timescale 1ns/1ps
`default_nettype none
module tbid_prog_mem
	import tbid_pkg::*;
(
	// clock and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// fetch side
	input  wire logic               fetch_strobe,
	output var  logic [INSTR_W-1:0] instr_in
);
	logic [INSTR_W-1:0] mem [0:63];
	logic [5:0]         pc;
	initial begin
		foreach (mem[i]) mem[i] = '0;
	end
	// outside the fetch slot the bus carries the inverted word xored with pc, so a late sample
	// cannot pick up the right word by luck
	always @(negedge clock) begin
		instr_in <= fetch_strobe ? mem[pc] : ~mem[pc] ^ {6'h00, pc};
	end
	always @(posedge clock) begin
		if (rst)
			pc <= '0;
		else if (fetch_strobe)
			pc <= pc + 6'h01;
	end
endmodule // tbid_prog_mem
`default_nettype wire

// [test/twelve_bit_instruction_decoder_test.sv]
// self-checking bench for the twelve-bit instruction decoder
`timescale 1ns/1ps
`default_nettype none
module twelve_bit_instruction_decoder_test;
	import tbid_pkg::*;
	logic                 clock, rst, skip_true, fetch_strobe, dest_select_r, literal_wide_r;
	logic                 is_skip_r, discard_r, w_write, f_write, pc_write, pc_bit8_clear;
	logic                 prog_mode_pin, id_we, id_re, id_rvalid_r;
	logic [INSTR_W-1:0]   instr_in, id_wdata, id_rdata_r;
	logic [ID_ADDR_W-1:0] id_addr;
	logic [5:0]           opcode_r;
	logic [FSEL_W-1:0]    file_select_r;
	logic [2:0]           bit_select_r;
	logic [LIT_W-1:0]     literal_r;
	tbid_class_t          class_r;
	tbid_ctl_t            ctl_op_r;
	tbid_phase_t          phase_r;
	logic [12:0]          prog [$];
	logic [22:0]          exp_q [$];
	logic [11:0]          id_q [$];
	logic [22:0]          e;
	logic [11:0]          v;
	int                   checks, mismatches, cnt, seed;
	bit                   q4_seen;

	tbid_decoder dut (.clock(clock), .rst(rst), .instr_in(instr_in),
		.fetch_strobe(fetch_strobe), .skip_true(skip_true), .opcode_r(opcode_r),
		.class_r(class_r), .file_select_r(file_select_r), .dest_select_r(dest_select_r),
		.bit_select_r(bit_select_r), .literal_r(literal_r), .literal_wide_r(literal_wide_r),
		.ctl_op_r(ctl_op_r), .is_skip_r(is_skip_r), .discard_r(discard_r), .phase_r(phase_r),
		.w_write(w_write), .f_write(f_write), .pc_write(pc_write),
		.pc_bit8_clear(pc_bit8_clear), .prog_mode_pin(prog_mode_pin), .id_we(id_we),
		.id_re(id_re), .id_addr(id_addr), .id_wdata(id_wdata), .id_rdata_r(id_rdata_r),
		.id_rvalid_r(id_rvalid_r));
	tbid_prog_mem mp (.clock(clock), .rst(rst), .fetch_strobe(fetch_strobe),
		.instr_in(instr_in));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic compare(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// expected {ctl, skip, discard, w, f, pc, pc8clr, class, field view}
	function automatic logic [22:0] expv(input logic [11:0] w, input logic disc);
		logic [1:0]  c;
		logic [11:0] s;
		logic        wr, fw, pw, cl, sk;
		tbid_ctl_t   k;
		if (disc)
			return 23'h040000;
		// a control word has its top seven bits clear; the no-op is one of them
		c = (w[11:5] == 7'h00) ? 2'h0 : (w[11:10] == 2'h0) ? 2'h1 :
			(w[11:10] == 2'h1) ? 2'h2 : 2'h3;
		// clear-w reads no file, so its low five bits must not show up
		s = (c == 2'h1) ? ((w[11:5] == 7'h02) ? {w[11:5], 5'h00} : w) :
			(c == 2'h2) ? {4'h0, w[7:0]} : (c == 2'h0) ? 12'h000 :
			(w[11:9] == 3'h5) ? {3'h0, w[8:0]} : {4'h0, w[7:0]};
		sk = (c == 2'h1 && (w[11:6] == 6'h0b || w[11:6] == 6'h0f)) || (c == 2'h2 && w[9]);
		k = TBID_CTL_NONE;
		if (c == 2'h0)
			k = (w[4:0] == 5'h02) ? TBID_CTL_OPTION : (w[4:0] == 5'h03) ? TBID_CTL_SLEEP :
				(w[4:0] == 5'h04) ? TBID_CTL_CLRWDT :
				(w[4:3] == 2'h0 && w[2:0] >= 3'h5) ? TBID_CTL_TRIS : TBID_CTL_NONE;
		else if (w[11:8] == 4'h9)
			k = TBID_CTL_CALL;
		else if (w[11:8] == 4'h8)
			k = TBID_CTL_RETURN;
		wr = (c == 2'h1 && !w[5]) || (c == 2'h3 && w[11:9] != 3'h5 && w[11:8] != 4'h9);
		fw = (c == 2'h1 && w[5]) || (c == 2'h2 && !w[9]);
		pw = c == 2'h3 && w[11:10] == 2'h2;
		cl = c == 2'h3 && w[11:9] == 3'h4;
		return {k, sk, 1'b0, wr, fw, pw, cl, c, s};
	endfunction

	always @(negedge clock) begin
		skip_true <= (mp.pc > 0 && mp.pc <= prog.size()) ? prog[mp.pc - 1][12] : 1'b0;
		cnt++;
		if (!rst && id_rvalid_r === 1'b1) begin
			compare(32'(id_q.size() > 0), 32'h1);
			if (id_q.size() > 0)
				compare(32'(id_rdata_r), 32'(id_q.pop_front()));
		end
		if (!rst && phase_r === TBID_Q4) begin
			if (q4_seen)
				compare(32'({cnt[7:0], fetch_strobe}), 32'h9);
			if (q4_seen && exp_q.size() > 0) begin
				e = exp_q.pop_front();
				case (class_r)
					TBID_CLS_BYTE: v = {opcode_r, dest_select_r, file_select_r};
					TBID_CLS_BIT:  v = {4'h0, bit_select_r, file_select_r};
					TBID_CLS_LIT:  v = literal_wide_r ? {3'h0, literal_r} : {4'h0, literal_r[7:0]};
					default:       v = 12'h000;
				endcase
				compare(32'({ctl_op_r, is_skip_r}), 32'(e[22:19]));
				compare(32'({discard_r, w_write, f_write, pc_write, pc_bit8_clear, class_r, v}),
					32'(e[18:0]));
			end
			q4_seen = 1'b1;
			cnt = 0;
		end
	end

	task automatic id_op(input logic we, input logic re, input int a, input logic [11:0] d);
		id_we = we;
		id_re = re;
		id_addr = a[ID_ADDR_W-1:0];
		id_wdata = d;
		@(negedge clock);
	endtask

	initial begin : main
		logic [11:0] w;
		logic        chg;
		int          r, n;
		rst = 1'b1;
		skip_true = 1'b0;
		prog_mode_pin = 1'b0;
		id_we = 1'b0;
		id_re = 1'b0;
		id_addr = '0;
		id_wdata = '0;
		seed = 32'h0aa3;
		prog = '{13'h0000, 13'h01c5, 13'h01e5, 13'h0ca5, 13'h0567, 13'h04e8, 13'h0ba3,
			13'h0cff, 13'h0942, 13'h0cff, 13'h0855, 13'h0cff, 13'h02c9, 13'h1723, 13'h0cff,
			13'h0644, 13'h13e9, 13'h0cff, 13'h0002, 13'h0003, 13'h0004, 13'h0006, 13'h0045};
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			prog.push_back({7'h07, r[5], (r[4:0] == 5'h02) ? 5'h03 : r[4:0]});
		end
		prog.push_back(13'h0000);
		@(negedge clock);
		chg = 1'b0;
		foreach (prog[i]) begin
			w = prog[i][11:0];
			mp.mem[i] = w;
			exp_q.push_back(expv(w, chg));
			chg = !chg && (w[11:10] == 2'h2 || prog[i][12]);
		end
		repeat (19) @(negedge clock);
		compare(32'({phase_r, w_write, f_write, pc_write, discard_r}), 32'h0);
		rst = 1'b0;
		n = 0;
		while (exp_q.size() > 0 && n < 400) begin
			@(negedge clock);
			n++;
		end
		compare(32'(exp_q.size()), 32'h0);
		$display("decode test done");
		prog_mode_pin = 1'b1;
		repeat (3) @(negedge clock);
		// data in the low nibble, upper eight bits all ones
		for (int i = 0; i < ID_WORDS; i++)
			id_op(1'b1, 1'b0, i, 12'hff0 | 12'(i));
		id_op(1'b0, 1'b0, 0, 12'h000);
		prog_mode_pin = 1'b0;
		repeat (3) @(negedge clock);
		id_op(1'b1, 1'b0, 1, 12'h000);
		id_op(1'b0, 1'b1, 1, 12'h000);
		id_op(1'b0, 1'b0, 0, 12'h000);
		prog_mode_pin = 1'b1;
		repeat (3) @(negedge clock);
		for (int i = 0; i < ID_WORDS; i++) begin
			id_q.push_back(12'hff0 | 12'(i));
			id_op(1'b0, 1'b1, i, 12'h000);
		end
		id_op(1'b0, 1'b0, 0, 12'h000);
		repeat (3) @(negedge clock);
		compare(32'(id_q.size()), 32'h0);
		$display("id test done");
		tally_and_finish();
	end

	initial begin : watchdog
		repeat (3000) @(posedge clock);
		mismatches++;
		tally_and_finish();
	end
endmodule // twelve_bit_instruction_decoder_test
`default_nettype wire
